// file: rtl/wwd_params.svh
// Purpose: constants for the windowed watchdog timer
// Assumes: 10 MHz system clock, 31 kHz low-power RC tick derived from it
// Notes:   byte offsets, field positions, reset values and timing counts
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// timing
`define WWD_CLK_PERIOD_NS      100
`define WWD_LOW_POWER_RC_OSCILLATOR_PERIOD_NS     32258
`define WWD_LOW_POWER_RC_OSCILLATOR_DIV_CYCLES    (`WWD_LOW_POWER_RC_OSCILLATOR_PERIOD_NS / `WWD_CLK_PERIOD_NS)
`define WWD_PRE_SHIFT_SHORT    5
`define WWD_PRE_SHIFT_LONG     7

// register byte offsets
`define WWD_OFS_RESET_CONTROL  4'h0
`define WWD_OFS_COUNT_STATUS   4'h4

// reset_control_reg fields
`define WWD_RC_SW_EN_BIT       5
`define WWD_RC_TIMEOUT_BIT     4
`define WWD_RC_SLEEP_BIT       3
`define WWD_RC_IDLE_BIT        2
`define WWD_RC_RESET_VALUE     32'h0000_0000

// count/status register fields
`define WWD_CS_PRE_LSB         0
`define WWD_CS_POST_LSB        8
`define WWD_CS_ENABLED_BIT     24
`define WWD_CS_WINDOW_BIT      25

// config_word_one fields
`define WWD_CFG_POST_MSB       3
`define WWD_CFG_POST_LSB       0
`define WWD_CFG_PRESCALE_BIT   4
`define WWD_CFG_WINDOW_DISABLE_CFG_BIT     6
`define WWD_CFG_HW_EN_BIT      7

`endif

// file: rtl/wwd_pkg.sv
// Purpose: types and shared arithmetic for the windowed watchdog timer
// Assumes: wwd_params.svh supplies the prescaler shifts; terminal counts and state codes are literals here
// Notes:   state of each module is one packed struct
`include "wwd_params.svh"

package wwd_pkg;

    typedef enum logic [2:0] {
        PWR_RUN   = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_IDLE  = 3'b100
    } wwd_pwr_e;

    typedef struct packed {
        logic [6:0] cnt;
    } wwd_pre_s;

    typedef struct packed {
        logic [14:0] cnt;
    } wwd_post_s;

    typedef struct packed {
        wwd_pwr_e    pwr;
        logic        sw_en;
        logic        to_flag;
        logic        sleep_flag;
        logic        idle_flag;
        logic [8:0]  osc_cnt;
        logic        osc_tick;
        logic        low_power_rc_oscillator_en;
        logic        wdt_rst;
        logic        wake;
        logic        waitreq;
        logic [31:0] rdata;
    } wwd_top_s;

    // terminal count of the prescaler
    function automatic logic [6:0] wwd_pre_last(input logic sel_long);
        wwd_pre_last = sel_long ? 7'h7f : 7'h1f;
    endfunction

    // last postscaler count is two to the power of the select field, minus one
    function automatic logic [14:0] wwd_post_last(input logic [3:0] sel);
        logic [15:0] r;
        r = 16'h0001 << sel;
        wwd_post_last = 15'(r - 16'h0001);
    endfunction

    // true in the last quarter of the programmed period
    function automatic logic wwd_window_open(input logic [6:0]  pre,
                                             input logic [14:0] post,
                                             input logic        sel_long,
                                             input logic [3:0]  sel);
        logic [4:0]  shift;
        logic [24:0] elapsed;
        logic [24:0] period;
        shift   = sel_long ? 5'(`WWD_PRE_SHIFT_LONG) : 5'(`WWD_PRE_SHIFT_SHORT);
        elapsed = (25'(post) << shift) + 25'(pre);
        period  = 25'h000_0001 << (shift + 5'(sel));
        wwd_window_open = (27'(elapsed) << 2) >= (27'(period) * 27'd3);
    endfunction

endpackage

// file: rtl/wwd_postscaler.sv
// Purpose: 1:1 to 1:32768 postscaler on the prescaler output
// Assumes: step is one clk_in cycle wide
// Notes:   timeout is combinational, clear wins over counting
`timescale 1ns/1ns
`default_nettype none

module wwd_postscaler
    import wwd_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // control
    input  wire logic       clear_in,
    input  wire logic       step_in,
    input  wire logic [3:0] sel_in,
    // result
    output logic [14:0]     count_out,
    output logic            timeout_out
);

    wwd_post_s st_q;
    wwd_post_s st_d;

    always_comb begin
        st_d        = st_q;
        timeout_out = 1'b0;
        if (clear_in) begin
            st_d.cnt = 15'h0000;
        end else if (step_in) begin
            if (st_q.cnt >= wwd_post_last(sel_in)) begin
                st_d.cnt    = 15'h0000;
                timeout_out = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    assign count_out = st_q.cnt;

endmodule

`default_nettype wire

// file: rtl/wwd_prescaler.sv
// Purpose: divide-by-32 or divide-by-128 prescaler on the oscillator tick
// Assumes: tick is one clk_in cycle wide
// Notes:   clear wins over counting; done is combinational
`timescale 1ns/1ns
`default_nettype none

module wwd_prescaler
    import wwd_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // control
    input  wire logic       clear_in,
    input  wire logic       tick_in,
    input  wire logic       sel_long_in,
    // result
    output logic [6:0]      count_out,
    output logic            done_out
);

    wwd_pre_s st_q;
    wwd_pre_s st_d;

    always_comb begin
        st_d     = st_q;
        done_out = 1'b0;
        if (clear_in) begin
            st_d.cnt = 7'h00;
        end else if (tick_in) begin
            if (st_q.cnt >= wwd_pre_last(sel_long_in)) begin
                st_d.cnt = 7'h00;
                done_out = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    assign count_out = st_q.cnt;

endmodule

`default_nettype wire

// file: rtl/wwd_top.sv
// Purpose: windowed watchdog timer with Avalon-MM register access
// Assumes: core strobes are one-cycle pulses synchronous to clk_in;
//          dev_reset_in is a synchronous pulse for every device reset
// Notes:   rst_in is power-on reset; flags survive dev_reset_in
//          0x0 control and flags, 0x4 count status, read only
//          flags clear on a written 0, a written 1 keeps them
//          one wait cycle per access, readdata stands at accept
//          clock switch clears counts in any state, wake event in sleep or idle only
//          power-save beats a timeout in the same cycle
//          oscillator tick is a fixed divide of clk_in
//          ce_in low freezes every count and the bus
//
// Summary of operation
// RULE_01: clock from low-power RC, enabled with watchdog
// RULE_02: prescaler divides by 32 or 128
// RULE_03: prescaler period 1 ms or 4 ms
// RULE_04: four-bit postscaler, sixteen ratios up to 32768
// RULE_05: postscaler ratio is two to field value
// RULE_06: any device reset clears all counts
// RULE_07: completed clock switch clears all counts
// RULE_08: power-save instruction clears all counts
// RULE_09: leaving sleep or idle clears all counts
// RULE_10: clear instruction in run clears all counts
// RULE_11: counting continues in sleep and idle
// RULE_12: timeout in sleep or idle wakes core
// RULE_13: timeout flag sticky until software clears it
// RULE_14: timeout while running resets the device
// RULE_15: windowed: early clear resets device like timeout
// RULE_16: window active when window-disable bit is zero
// RULE_17: hardware enable bit forces watchdog on
// RULE_18: otherwise software bit enables and disables it
// RULE_19: every device reset clears software enable bit
`timescale 1ns/1ns
`default_nettype none

`include "wwd_params.svh"

module wwd_top
    import wwd_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        dev_reset_in,
    // configuration word
    input  wire logic [7:0]  config_word_one_in,
    // core events
    input  wire logic        power_save_instruction_in,
    input  wire logic        power_save_idle_in,
    input  wire logic        watchdog_clear_instruction_in,
    input  wire logic        clock_switch_done_in,
    input  wire logic        wake_event_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // watchdog outputs
    output logic             watchdog_reset_out,
    output logic             wake_out,
    output logic             low_power_rc_oscillator_en_out,
    output logic             timeout_flag_out
);

    wwd_top_s st_q;
    wwd_top_s st_d;

    // configuration fields
    logic [3:0]  postscale_select_cfg;
    logic        prescale_select_cfg;
    logic        window_disable_cfg;
    logic        hw_enable_cfg;

    // counter chain
    logic        enabled;
    logic        clear_all;
    logic        pre_done;
    logic [6:0]  pre_cnt;
    logic [14:0] post_cnt;
    logic        timeout;

    // clear and window decode
    logic        in_run;
    logic        window_open;
    logic        clr_req;
    logic        clr_early;
    logic        exit_save;

    // bus
    logic        bus_req;
    logic        bus_accept;
    logic        rc_write;
    logic [31:0] rd_mux;

    assign postscale_select_cfg = config_word_one_in[`WWD_CFG_POST_MSB:`WWD_CFG_POST_LSB];
    assign prescale_select_cfg  = config_word_one_in[`WWD_CFG_PRESCALE_BIT];
    assign window_disable_cfg   = config_word_one_in[`WWD_CFG_WINDOW_DISABLE_CFG_BIT];
    assign hw_enable_cfg        = config_word_one_in[`WWD_CFG_HW_EN_BIT];

    // software cannot override the hardware enable
    assign enabled = hw_enable_cfg | st_q.sw_en; // RULE_17 RULE_18

    // counting never stops in sleep or idle
    assign in_run  = (st_q.pwr == PWR_RUN);

    // clear instruction only counts during normal execution
    assign clr_req     = watchdog_clear_instruction_in & in_run & enabled;

    // window test on live counts, in oscillator ticks
    assign window_open = wwd_window_open(pre_cnt, post_cnt, prescale_select_cfg,
                                         postscale_select_cfg);

    // an early clear still zeroes the counts, so the
    // reset that follows restarts a full period
    assign clr_early   = clr_req & ~window_disable_cfg & ~window_open; // RULE_15 RULE_16

    // leaving a power-save mode through another wake source;
    // a timeout wake needs no term: both counters wrap to zero
    assign exit_save = ~in_run & wake_event_in;

    // all sources zero prescaler and postscaler together;
    // a disabled watchdog holds both at zero
    assign clear_all = dev_reset_in                          // RULE_06
                     | clock_switch_done_in                  // RULE_07
                     | (power_save_instruction_in & in_run)  // RULE_08
                     | exit_save                             // RULE_09
                     | clr_req                               // RULE_10
                     | ~enabled;

    // prescaler steps on each oscillator tick
    wwd_prescaler u_pre (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .clear_in    (clear_all),
        .tick_in     (st_q.osc_tick),
        .sel_long_in (prescale_select_cfg),
        .count_out   (pre_cnt),
        .done_out    (pre_done)
    ); // RULE_02 RULE_03

    // postscaler steps on each prescaler wrap;
    // its own wrap is the timeout
    wwd_postscaler u_post (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .clear_in    (clear_all),
        .step_in     (pre_done),
        .sel_in      (postscale_select_cfg),
        .count_out   (post_cnt),
        .timeout_out (timeout)
    ); // RULE_04 RULE_05 RULE_11

    // avalon handshake: one wait cycle, then accept;
    // ce_in low stretches both cycles
    assign bus_req    = avs_read_in | avs_write_in;
    assign bus_accept = bus_req & ~st_q.waitreq;

    // control bits sit in byte lane 0 only
    assign rc_write   = bus_accept & avs_write_in & avs_byteenable_in[0]
                      & (avs_address_in == `WWD_OFS_RESET_CONTROL);

    // read decode, unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_in)
            `WWD_OFS_RESET_CONTROL: begin
                rd_mux[`WWD_RC_SW_EN_BIT]   = st_q.sw_en;
                rd_mux[`WWD_RC_TIMEOUT_BIT] = st_q.to_flag;
                rd_mux[`WWD_RC_SLEEP_BIT]   = st_q.sleep_flag;
                rd_mux[`WWD_RC_IDLE_BIT]    = st_q.idle_flag;
            end

            `WWD_OFS_COUNT_STATUS: begin
                rd_mux[`WWD_CS_PRE_LSB +: 7]    = pre_cnt;
                rd_mux[`WWD_CS_POST_LSB +: 15]  = post_cnt;
                rd_mux[`WWD_CS_ENABLED_BIT]     = enabled;
                rd_mux[`WWD_CS_WINDOW_BIT]      = window_open;
            end

            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        st_d = st_q;

        // oscillator runs only while the watchdog is enabled
        st_d.low_power_rc_oscillator_en  = enabled; // RULE_01
        st_d.osc_tick = 1'b0;

        // one tick per oscillator period;
        // disabling restarts the oscillator phase
        if (!enabled) begin
            st_d.osc_cnt = 9'h000;
        end else if (st_q.osc_cnt >= 9'(`WWD_LOW_POWER_RC_OSCILLATOR_DIV_CYCLES - 1)) begin
            st_d.osc_cnt  = 9'h000;
            st_d.osc_tick = 1'b1; // RULE_01
        end else begin
            st_d.osc_cnt = st_q.osc_cnt + 9'h001;
        end

        // reset and wake requests are one-cycle pulses
        st_d.wdt_rst = 1'b0;
        st_d.wake    = 1'b0;

        // software writes: enable bit follows data, flags can only be cleared;
        // a hardware set further down wins over a clear in this cycle
        if (rc_write) begin
            st_d.sw_en      = avs_writedata_in[`WWD_RC_SW_EN_BIT]; // RULE_18
            st_d.to_flag    = st_q.to_flag    & avs_writedata_in[`WWD_RC_TIMEOUT_BIT];
            st_d.sleep_flag = st_q.sleep_flag & avs_writedata_in[`WWD_RC_SLEEP_BIT];
            st_d.idle_flag  = st_q.idle_flag  & avs_writedata_in[`WWD_RC_IDLE_BIT];
        end

        // power state, one-hot
        case (st_q.pwr)
            PWR_RUN: begin
                // power-save first: a timeout in this cycle is dropped
                if (power_save_instruction_in) begin
                    if (power_save_idle_in) begin
                        st_d.pwr       = PWR_IDLE;
                        st_d.idle_flag = 1'b1;
                    end else begin
                        st_d.pwr        = PWR_SLEEP;
                        st_d.sleep_flag = 1'b1;
                    end
                end else if (timeout || clr_early) begin
                    st_d.wdt_rst = 1'b1; // RULE_14 RULE_15
                    st_d.to_flag = 1'b1; // RULE_13
                end
            end

            PWR_SLEEP, PWR_IDLE: begin
                // timeout wakes instead of resetting
                if (timeout) begin
                    st_d.pwr     = PWR_RUN;
                    st_d.wake    = 1'b1; // RULE_12
                    st_d.to_flag = 1'b1; // RULE_13
                end else if (wake_event_in) begin
                    st_d.pwr  = PWR_RUN;
                    st_d.wake = 1'b1;
                end
            end

            default: begin
                // illegal code: recover to run
                st_d.pwr = PWR_RUN;
            end
        endcase

        // device reset: back to run, software enable dropped;
        // last, so it overrides the power state, enable and pulses set above; flags are
        // kept so software can tell why the core restarted
        if (dev_reset_in) begin
            st_d.pwr     = PWR_RUN;
            st_d.sw_en   = 1'b0; // RULE_19
            st_d.wake    = 1'b0;
            st_d.wdt_rst = 1'b0;
        end

        // bus timing: readdata loads in the wait cycle
        // and stands at the accept edge
        st_d.waitreq = ~(bus_req & st_q.waitreq);
        if (bus_req && st_q.waitreq) begin
            st_d.rdata = avs_read_in ? rd_mux : 32'h0000_0000;
        end
    end

    // power-on reset alone clears the flags
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q            <= '0;
            st_q.pwr        <= PWR_RUN;
            st_q.sw_en      <= 1'b0; // RULE_19
            st_q.waitreq    <= 1'b1;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    // every output is a bit of the registered state
    assign avs_readdata_out               = st_q.rdata;
    assign avs_waitrequest_out            = st_q.waitreq;

    assign watchdog_reset_out             = st_q.wdt_rst;
    assign wake_out                       = st_q.wake;
    assign low_power_rc_oscillator_en_out = st_q.low_power_rc_oscillator_en;
    assign timeout_flag_out               = st_q.to_flag;

endmodule

`default_nettype wire

// file: verification/wwd_core_model.sv
// Purpose: processor core model issuing watchdog events
// Assumes: bench command held for one cycle
// Notes:   a watchdog reset request becomes a device reset
`timescale 1ns/1ns
`default_nettype none
module wwd_core_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // bench command, watchdog request
    input  wire logic [2:0] cmd_in,
    input  wire logic       watchdog_reset_in,
    // core events
    output logic            power_save_out,
    output logic            idle_out,
    output logic            clear_out,
    output logic            clock_switch_out,
    output logic            wake_out,
    output logic            dev_reset_out
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            power_save_out   <= 1'b0;
            idle_out         <= 1'b0;
            clear_out        <= 1'b0;
            clock_switch_out <= 1'b0;
            wake_out         <= 1'b0;
            dev_reset_out    <= 1'b0;
        end else begin
            power_save_out   <= cmd_in == 3'd2 || cmd_in == 3'd3;
            idle_out         <= cmd_in == 3'd3;
            clear_out        <= cmd_in == 3'd1;
            clock_switch_out <= cmd_in == 3'd4;
            wake_out         <= cmd_in == 3'd5;
            dev_reset_out    <= watchdog_reset_in;
        end
    end
endmodule
`default_nettype wire

// file: verification/wwd_top_monitor.sv
// Purpose: port checker bound to wwd_top
// Assumes: one clock, no pulse frozen by ce_in
// Notes:   bind statement at the foot
`timescale 1ns/1ns
`default_nettype none
`include "wwd_params.svh"
module wwd_top_monitor (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        rst_in,
    // watched inputs
    input wire logic [7:0]  config_word_one_in,
    input wire logic        wake_event_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    // watched outputs
    input wire logic        avs_waitrequest_out,
    input wire logic        watchdog_reset_out,
    input wire logic        wake_out,
    input wire logic        low_power_rc_oscillator_en_out,
    input wire logic        timeout_flag_out
);
    logic wr_rc;
    logic clr_rc;
    logic osc;
    assign wr_rc = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
        && avs_address_in == `WWD_OFS_RESET_CONTROL;
    assign clr_rc = wr_rc && !avs_writedata_in[`WWD_RC_TIMEOUT_BIT];
    assign osc = low_power_rc_oscillator_en_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rst_pulse_a: assert property (watchdog_reset_out |=> !watchdog_reset_out)
        else $error("watchdog reset pulse too long");
    wake_pulse_a: assert property (wake_out |=> !wake_out)
        else $error("wake pulse too long");
    wake_excl_a: assert property (wake_out |-> !watchdog_reset_out)
        else $error("wake and watchdog reset together");
    rst_flag_a: assert property (watchdog_reset_out |-> timeout_flag_out)
        else $error("watchdog reset without timeout flag");
    wake_flag_a: assert property (wake_out && !$past(wake_event_in)
        |-> timeout_flag_out) else $error("wake without timeout flag");
    flag_sticky_a: assert property ($fell(timeout_flag_out) |->
        $past(clr_rc) || $past(clr_rc, 2)) else $error("timeout flag lost");
    hw_on_a: assert property (config_word_one_in[7] [*3] |-> osc)
        else $error("hardware enable ignored");
    sw_on_a: assert property (wr_rc && avs_writedata_in[5] |-> ##[1:3] osc)
        else $error("software enable ignored");
    off_quiet_a: assert property (!osc [*4] |-> !watchdog_reset_out
        && (!wake_out || $past(wake_event_in))) else $error("event while disabled");
    cover property (wake_out);
    cover property (watchdog_reset_out);
    cover property (clr_rc);
endmodule
bind wwd_top wwd_top_monitor u_wwd_top_monitor (
    .clk_in(clk_in), .rst_in(rst_in), .config_word_one_in(config_word_one_in),
    .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_waitrequest_out(avs_waitrequest_out), .watchdog_reset_out(watchdog_reset_out),
    .wake_out(wake_out), .timeout_flag_out(timeout_flag_out),
    .wake_event_in(wake_event_in),
    .low_power_rc_oscillator_en_out(low_power_rc_oscillator_en_out)
);
`default_nettype wire

// file: verification/wwd_top_tb.sv
// Purpose: self-checking bench for wwd_top
// Assumes: byte enables held high
// Notes:   flag and count model kept in integers
`timescale 1ns/1ns
`default_nettype none
`include "wwd_params.svh"
module wwd_top_tb;
    localparam int TK = `WWD_LOW_POWER_RC_OSCILLATOR_DIV_CYCLES;
    localparam logic [3:0] RC = `WWD_OFS_RESET_CONTROL;
    localparam logic [3:0] CS = `WWD_OFS_COUNT_STATUS;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  cfg = 8'h40;
    logic [2:0]  cmd = 3'd0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata, q;
    logic        wreq, wrst, wake, osc, flag;
    logic        ps, psi, clr, csw, wev, drst;
    logic [1:0]  hit;
    logic [2:0]  evs [6] = '{3'd1, 3'd4, 3'd2, 3'd5, 3'd3, 3'd5};
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          seed = 32'h8c98a1ac;
    int          m_sw, m_to, m_sl, m_id, n, i;

    always #50 clk_in = ~clk_in;

    wwd_top u_wwd_top (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .dev_reset_in(drst),
        .config_word_one_in(cfg), .power_save_instruction_in(ps),
        .power_save_idle_in(psi), .watchdog_clear_instruction_in(clr),
        .clock_switch_done_in(csw), .wake_event_in(wev), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .watchdog_reset_out(wrst), .wake_out(wake),
        .low_power_rc_oscillator_en_out(osc), .timeout_flag_out(flag));
    wwd_core_model u_wwd_core_model (
        .clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .watchdog_reset_in(wrst),
        .power_save_out(ps), .idle_out(psi), .clear_out(clr),
        .clock_switch_out(csw), .wake_out(wev), .dev_reset_out(drst));

    task automatic complete_run();
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk_in);
        end while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic ev(input logic [2:0] c);
        @(posedge clk_in);
        cmd <= c;
        @(posedge clk_in);
        cmd <= 3'd0;
    endtask

    task automatic ticks(input int t);
        repeat (t * TK) @(posedge clk_in);
    endtask

    task automatic wait_out(input int lim);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (wrst !== 1'b1 && wake !== 1'b1 && n < lim);
        hit = {wrst, wake};
    endtask

    function automatic logic in_rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction

    function automatic logic [31:0] m_rc();
        return 32'((m_sw << 5) | (m_to << 4) | (m_sl << 3) | (m_id << 2));
    endfunction

    initial begin
        m_sw = 0;
        m_to = 0;
        m_sl = 0;
        m_id = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        bus(1'b0, RC, 32'h0);
        chk(q, `WWD_RC_RESET_VALUE);
        bus(1'b0, CS, 32'h0);
        chk(q, 32'h0000_0000);
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0000_0000);
        chk(osc, 1'b0);
        bus(1'b1, RC, ($random(seed) & 32'hffff_ffc3) | 32'h0000_0020);
        m_sw = 1;
        bus(1'b0, RC, 32'h0);
        chk(q & 32'h0000_003c, m_rc());
        repeat (3) @(posedge clk_in);
        chk(osc, 1'b1);
        // clear, clock switch, power-save and wake events, counts seen before and after
        foreach (evs[i]) begin
            ticks(8);
            bus(1'b0, CS, 32'h0);
            chk(in_rng(int'(q[6:0]), 6, 9), 1'b1);
            ev(evs[i]);
            m_sl = m_sl | (evs[i] == 3'd2);
            m_id = m_id | (evs[i] == 3'd3);
            bus(1'b0, CS, 32'h0);
            chk(in_rng(int'(q[22:0]), 0, 1), 1'b1);
        end
        bus(1'b0, RC, 32'h0);
        chk(q & 32'h0000_003c, m_rc());
        ev(3'd2);
        wait_out(40 * TK);
        chk(hit, 2'b01);
        chk(in_rng(n, 31 * TK - 5, 32 * TK + 10), 1'b1);
        m_to = 1;
        bus(1'b0, RC, 32'h0);
        chk(q & 32'h0000_003c, m_rc());
        bus(1'b1, RC, 32'h0000_0020);
        m_to = 0;
        m_sl = 0;
        m_id = 0;
        bus(1'b0, RC, 32'h0);
        chk(q & 32'h0000_003c, m_rc());
        chk(flag, 1'b0);
        ev(3'd4);
        wait_out(40 * TK);
        chk(hit, 2'b10);
        chk(in_rng(n, 31 * TK - 5, 32 * TK + 10), 1'b1);
        repeat (4) @(posedge clk_in);
        m_to = 1;
        m_sw = 0;
        bus(1'b0, RC, 32'h0);
        chk(q & 32'h0000_003c, m_rc());
        chk(osc, 1'b0);
        bus(1'b1, RC, 32'h0000_0020);
        for (i = 0; i < 2; i++) begin
            cfg <= i ? 8'h43 : 8'h50;
            ev(3'd4);
            ticks(36 + 4 * i);
            bus(1'b0, CS, 32'h0);
            n = int'(q[22:8]) * (i ? 32 : 128) + int'(q[6:0]);
            chk(in_rng(n, 33 + 4 * i, 37 + 4 * i), 1'b1);
        end
        bus(1'b1, RC, 32'h0);
        cfg <= 8'h80;
        repeat (3) @(posedge clk_in);
        chk(osc, 1'b1);
        ev(3'd4);
        ticks(4 + $unsigned($random(seed)) % 15);
        ev(3'd1);
        wait_out(10);
        chk(hit, 2'b10);
        repeat (4) @(posedge clk_in);
        ticks(26);
        ev(3'd1);
        wait_out(20);
        chk(hit, 2'b00);
        bus(1'b0, CS, 32'h0);
        chk(in_rng(int'(q[6:0]), 0, 1), 1'b1);
        // clock enable low: counts must not advance
        ce <= 1'b0;
        ticks(3);
        ce <= 1'b1;
        bus(1'b0, CS, 32'h0);
        chk(in_rng(int'(q[6:0]), 0, 2), 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
